/* File: logic/hbs_fault_guard.sv */
// hbs_fault_guard: sticky fault flags and shutdown timers.
// assumes fault inputs are already synchronised to i_clk_sys.
`timescale 1ns/10ps
module hbs_fault_guard import hbs_pkg::*; #(
  parameter int unsigned SHORT_LONG_CYC  = SHORT_LONG_US * SYS_CLK_MHZ,
  parameter int unsigned SHORT_SHORT_CYC = SHORT_SHORT_US * SYS_CLK_MHZ,
  parameter int unsigned UV_DELAY_CYC    = UV_DELAY_US * SYS_CLK_MHZ
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  hbs_fault_if.guard f
);
  logic [TMR_W-1:0]    uv_cnt_q;
  logic                uv_done;
  logic [SW_COUNT-1:0] dis_set;
  int unsigned         short_lim;

  assign short_lim = f.short_delay_long ? SHORT_LONG_CYC : SHORT_SHORT_CYC;
  assign uv_done   = f.supply_under & hbs_reached(uv_cnt_q, UV_DELAY_CYC);

  // ==========================================================
  // undervoltage: cut outputs after the delay, release at once
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      uv_cnt_q           <= '0;
      f.supply_cut       <= 1'b0;
      f.supply_fail_flag <= 1'b0;
    end else begin
      uv_cnt_q     <= (f.supply_under && !uv_done) ?
                      uv_cnt_q + 1'b1 : (f.supply_under ? uv_cnt_q : '0);
      f.supply_cut <= f.supply_under & (f.supply_cut | uv_done);
      // (R8) set wins over clear
      f.supply_fail_flag <= uv_done | (f.supply_fail_flag & ~f.clear_req);
    end
  end

  // ==========================================================
  // per-switch short timers
  for (genvar i = 0; i < SW_COUNT; i++) begin : g_short
    logic [TMR_W-1:0] cnt_q;
    logic             shorted;
    assign shorted = f.short_det[i] & f.switch_on[i];
    // (R11) delay from select bit
    assign dis_set[i] = shorted &
                        (f.thermal_warn | hbs_reached(cnt_q, short_lim));
    always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
        cnt_q               <= '0;
        f.switch_disable[i] <= 1'b0;
      end else begin
        cnt_q <= (shorted && !dis_set[i]) ? cnt_q + 1'b1 : '0;
        f.switch_disable[i] <= dis_set[i] |
                               (f.switch_disable[i] & ~f.clear_req);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      f.short_fault_flag <= 1'b0;
      f.overtemp_flag    <= 1'b0;
    end else begin
      // (R15) latch short shutdown
      f.short_fault_flag <= (|dis_set) | (f.short_fault_flag & ~f.clear_req);
      // (R8) overtemp clears only once cool
      f.overtemp_flag    <= f.thermal_shutdown |
                            (f.overtemp_flag & ~f.clear_req);
    end
  end
endmodule

/* File: logic/hbs_pin_sync.sv */
// hbs_pin_sync: three-stage synchroniser with agreement filter per bit.
// assumes inputs are asynchronous to i_clk_sys.
`timescale 1ns/10ps
module hbs_pin_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;

  // level moves only when the second and third stage agree
  assign lvl_d   = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  assign o_level = lvl_q;
  assign o_rise  = lvl_d & ~lvl_q;
  assign o_fall  = ~lvl_d & lvl_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q  <= i_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end
endmodule

/* File: logic/hbs_serial_ctl.sv */
// hbs_serial_ctl: serial control port of a six-channel half-bridge driver.
// assumes select, serial clock, data and fault inputs are asynchronous pins;
// the serial clock must be slow enough to be oversampled by i_clk_sys.
//
// Summary of operation
// (R1) falling select starts a new serial frame
// (R2) input bit sampled on each falling serial clock edge
// (R3) host shifts control word LSB first, clear request first
// (R4) new control word applied only on rising select
// (R5) output hi-Z while deselected, driven from falling select
// (R6) output bit changes only on rising serial clock edges
// (R7) status word shifted out LSB first, thermal warning first
// (R8) clear request bit clears supply, short and overtemp flags
// (R9) bits 1 to 12 drive low and high switches, high is on
// (R10) bit 13 low enables open-load check, high disables
// (R11) bit 14 picks short shutdown delay, 12 ms high, 1.5 ms low
// (R12) bit 15 low is standby; serial port keeps working
// (R13) status bit 0 shows thermal warning
// (R14) status 1..12 show switch state, or open load when checking
// (R15) status 13 set once a short switched an output off
// (R16) status 14 high when software or pin requests standby
// (R17) status 15 shows supply undervoltage fail
// (R18) overtemperature shutdown forces all sixteen status bits high
// (R19) after reset control holds bits 15, 14, 13 high, rest low
// (R20) a control frame is exactly sixteen bits
// (R21) clock and data ignored while select is high
// (R22) low standby pin forces standby
// (R23) select pulse without clocks changes no register
// (R24) status captured at falling select for shifting out
`timescale 1ns/10ps
module hbs_serial_ctl import hbs_pkg::*; #(
  parameter int unsigned SHORT_LONG_CYC  = SHORT_LONG_US * SYS_CLK_MHZ,
  parameter int unsigned SHORT_SHORT_CYC = SHORT_SHORT_US * SYS_CLK_MHZ,
  parameter int unsigned UV_DELAY_CYC    = UV_DELAY_US * SYS_CLK_MHZ
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rstn,
  input  wire logic                i_sel_n,
  input  wire logic                i_sclk,
  input  wire logic                i_serial_in,
  input  wire logic                i_standby_request_n,
  input  wire logic                i_thermal_warn,
  input  wire logic                i_thermal_shutdown,
  input  wire logic                i_supply_under,
  input  wire logic [SW_COUNT-1:0] i_short_det,
  input  wire logic [SW_COUNT-1:0] i_open_load,
  output logic                     o_serial_out,
  output logic                     o_serial_out_oe,
  output logic      [SW_COUNT-1:0] o_switch_on,
  output logic                     o_open_load_check_n,
  output logic                     o_standby,
  output logic      [15:0]         o_control_word,
  output logic      [15:0]         o_status_word
);

  // ==========================================================
  // elaboration checks
  if (SHORT_LONG_CYC < 1 || SHORT_LONG_CYC >= 2 ** TMR_W)
    $error("short long delay does not fit the timer");
  if (SHORT_SHORT_CYC < 1 || SHORT_SHORT_CYC >= 2 ** TMR_W)
    $error("short short delay does not fit the timer");
  if (UV_DELAY_CYC < 1 || UV_DELAY_CYC >= 2 ** TMR_W)
    $error("undervoltage delay does not fit the timer");

  // ==========================================================
  // pin synchronisers
  localparam int unsigned ENV_W = 2 * SW_COUNT + 4;

  logic [2:0]       lnk_lvl;
  logic [2:0]       lnk_rise;
  logic [2:0]       lnk_fall;
  logic [ENV_W-1:0] env_lvl;

  hbs_pin_sync #(
    .W       (3),
    .RST_VAL (3'h1)
  ) u_link_sync (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_pin     ({i_serial_in, i_sclk, i_sel_n}),
    .o_level   (lnk_lvl),
    .o_rise    (lnk_rise),
    .o_fall    (lnk_fall)
  );

  hbs_pin_sync #(
    .W       (ENV_W),
    .RST_VAL ('0)
  ) u_env_sync (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_pin     ({i_open_load, i_short_det, i_supply_under,
                 i_thermal_shutdown, i_thermal_warn, i_standby_request_n}),
    .o_level   (env_lvl),
    .o_rise    (),
    .o_fall    ()
  );

  wire                sel_n_lvl  = lnk_lvl[0];
  wire                sel_fall   = lnk_fall[0];
  wire                sel_rise   = lnk_rise[0];
  wire                sclk_rise  = lnk_rise[1];
  wire                sclk_fall  = lnk_fall[1];
  wire                din_lvl    = lnk_lvl[2];
  wire                inh_n_lvl  = env_lvl[0];
  wire                t_warn     = env_lvl[1];
  wire                t_shut     = env_lvl[2];
  wire                v_under    = env_lvl[3];
  wire [SW_COUNT-1:0] short_lvl  = env_lvl[SW_COUNT+3:4];
  wire [SW_COUNT-1:0] open_lvl   = env_lvl[ENV_W-1:SW_COUNT+4];

  // ==========================================================
  // fault guard
  hbs_fault_if fif ();

  hbs_fault_guard #(
    .SHORT_LONG_CYC  (SHORT_LONG_CYC),
    .SHORT_SHORT_CYC (SHORT_SHORT_CYC),
    .UV_DELAY_CYC    (UV_DELAY_CYC)
  ) u_guard (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .f         (fif.guard)
  );

  // ==========================================================
  // registers
  logic [15:0] ctl_q;
  logic [15:0] shin_q;
  logic [15:0] snap_q;
  logic [4:0]  cnt_q;
  logic        clr_q;
  logic        sel_q;

  assign fif.short_delay_long = ctl_q[CTL_SCT_BIT];
  assign fif.clear_req        = clr_q;
  assign fif.switch_on        = o_switch_on;
  assign fif.thermal_warn     = t_warn;
  assign fif.thermal_shutdown = t_shut;
  assign fif.supply_under     = v_under;
  assign fif.short_det        = short_lvl;

  // ==========================================================
  // status word assembly
  wire [SW_COUNT-1:0] sw_cmd = ctl_q[CTL_SW_LSB +: SW_COUNT];
  // (R10) low bit enables open-load check
  wire                olc_on = ~ctl_q[CTL_OLC_BIT];
  // (R16) software or pin standby
  // (R22) pin low forces standby
  wire                stby   = ~ctl_q[CTL_RUN_BIT] | ~inh_n_lvl;
  // (R14) open load only seen while off
  wire [SW_COUNT-1:0] sw_stat = olc_on ?
                        ((open_lvl & ~o_switch_on) | o_switch_on) :
                        o_switch_on;
  // (R13) warning at bit 0
  // (R15) short flag at bit 13
  // (R17) supply fail at bit 15
  wire [15:0]         st_raw = {fif.supply_fail_flag, stby,
                                fif.short_fault_flag, sw_stat, t_warn};
  // (R18) shutdown forces all ones
  wire [15:0]         st_now = fif.overtemp_flag ? ST_ALL_ONES : st_raw;
  // (R9) switches gated by every shutdown cause
  // (R12) standby turns stages off only
  wire                cut_all = stby | fif.supply_cut | fif.overtemp_flag;
  wire [SW_COUNT-1:0] sw_d    = sw_cmd & ~fif.switch_disable &
                                {SW_COUNT{~cut_all}};

  // ==========================================================
  // frame decode
  // (R21) edges count only while selected
  wire in_frame  = sel_q & ~sel_fall & ~sel_rise;
  // (R2) sample on falling clock
  wire take_bit  = in_frame & sclk_fall;
  // (R6) advance output on rising clock
  wire next_bit  = in_frame & sclk_rise & (cnt_q != CNT_ZERO) &
                   (cnt_q < CNT_FULL);
  // (R20) exactly sixteen bits
  // (R23) no clocks, no change
  wire commit    = sel_rise & sel_q & (cnt_q == CNT_FULL);

  // ==========================================================
  // serial shift and frame tracking
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      sel_q  <= 1'b0;
      cnt_q  <= CNT_ZERO;
      shin_q <= '0;
      snap_q <= '0;
    end else begin
      if (sel_fall) begin
        // (R1) new frame on falling select
        sel_q  <= 1'b1;
        cnt_q  <= CNT_ZERO;
        // (R24) capture status at start
        snap_q <= st_now;
      end else if (sel_rise || sel_n_lvl) begin
        sel_q <= 1'b0;
      end else if (take_bit) begin
        // (R3) first bit lands at bit 0
        shin_q <= {din_lvl, shin_q[15:1]};
        cnt_q  <= (cnt_q == CNT_OVER) ? CNT_OVER : cnt_q + 5'h01;
      end
    end
  end

  // ==========================================================
  // control word
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      // (R19) power-on control value
      ctl_q <= CTL_RESET;
      clr_q <= 1'b0;
    end else begin
      // (R4) apply on rising select
      if (commit) begin
        ctl_q <= shin_q;
      end
      // (R8) one-cycle clear request
      clr_q <= commit & shin_q[CTL_CLEAR_BIT];
    end
  end

  // ==========================================================
  // serial output pin
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else begin
      if (sel_fall) begin
        // (R5) drive from falling select
        o_serial_out_oe <= 1'b1;
        // (R7) thermal warning goes first
        o_serial_out    <= st_now[0];
      end else if (sel_rise || sel_n_lvl) begin
        // (R5) release when deselected
        o_serial_out_oe <= 1'b0;
      end else if (next_bit) begin
        // (R6) change only on rising clock
        o_serial_out <= snap_q[cnt_q[3:0]];
      end
    end
  end

  // ==========================================================
  // driver outputs and visibility
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_switch_on         <= '0;
      o_open_load_check_n <= CTL_RESET[CTL_OLC_BIT];
      o_standby           <= 1'b1;
      o_control_word      <= CTL_RESET;
      o_status_word       <= '0;
    end else begin
      // (R9) high turns switch on
      o_switch_on         <= sw_d;
      // (R10) drive check sources
      o_open_load_check_n <= ctl_q[CTL_OLC_BIT];
      o_standby           <= stby;
      o_control_word      <= ctl_q;
      o_status_word       <= st_now;
    end
  end

endmodule

/* File: pkg/hbs_fault_if.sv */
// hbs_fault_if: signals between the serial control core and fault guard.
// assumes both ends run on i_clk_sys.
`timescale 1ns/10ps
interface hbs_fault_if;
  import hbs_pkg::*;
  logic                short_delay_long;
  logic                clear_req;
  logic [SW_COUNT-1:0] switch_on;
  logic                thermal_warn;
  logic                thermal_shutdown;
  logic                supply_under;
  logic [SW_COUNT-1:0] short_det;
  logic                supply_fail_flag;
  logic                short_fault_flag;
  logic                overtemp_flag;
  logic                supply_cut;
  logic [SW_COUNT-1:0] switch_disable;

  modport core (
    output short_delay_long, clear_req, switch_on, thermal_warn,
           thermal_shutdown, supply_under, short_det,
    input  supply_fail_flag, short_fault_flag, overtemp_flag, supply_cut,
           switch_disable
  );
  modport guard (
    input  short_delay_long, clear_req, switch_on, thermal_warn,
           thermal_shutdown, supply_under, short_det,
    output supply_fail_flag, short_fault_flag, overtemp_flag, supply_cut,
           switch_disable
  );
endinterface

/* File: pkg/hbs_pkg.sv */
// hbs_pkg: shared constants for the half-bridge serial control block.
// assumes a single 50 MHz system clock and a 16-bit serial frame.
package hbs_pkg;

  // ==========================================================
  // frame and clock
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned SW_COUNT    = 12;
  localparam int unsigned SYS_CLK_MHZ = 50;
  localparam int unsigned TMR_W       = 20;

  // ==========================================================
  // timing, in microseconds as specified
  localparam int unsigned SHORT_LONG_US  = 12000;
  localparam int unsigned SHORT_SHORT_US = 1500;
  localparam int unsigned UV_DELAY_US    = 100;

  // ==========================================================
  // control word layout
  localparam logic [15:0] CTL_RESET     = 16'hE000;
  localparam int unsigned CTL_CLEAR_BIT = 0;
  localparam int unsigned CTL_SW_LSB    = 1;
  localparam int unsigned CTL_OLC_BIT   = 13;
  localparam int unsigned CTL_SCT_BIT   = 14;
  localparam int unsigned CTL_RUN_BIT   = 15;

  // ==========================================================
  // status word value and frame bit counter values
  localparam logic [15:0] ST_ALL_ONES   = 16'hFFFF;
  localparam logic [4:0]  CNT_FULL      = 5'h10;
  localparam logic [4:0]  CNT_OVER      = 5'h11;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;

  // ==========================================================
  // timer compare, shared by every delay counter
  function automatic logic hbs_reached(input logic [TMR_W-1:0] cnt,
                                       input int unsigned      lim);
    hbs_reached = (32'(cnt) + 32'h1) >= lim;
  endfunction

endpackage

/* File: testbench/hbs_host_model.sv */
// hbs_host_model: host controller acting as master of the serial link.
// assumes the device pins idle at their pull levels between frames.
`timescale 1ns/10ps
module hbs_host_model #(
  parameter int HALF_NS = 80
) (
  output logic      o_sel_n,
  output logic      o_sclk,
  output logic      o_serial_in,
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_oe
);
  initial begin
    o_sel_n = 1'b1;
    o_sclk = 1'b0;
    o_serial_in = 1'b0;
  end

  // ==========================================================
  // one frame; output is read at the end of each low phase because
  // the device shows a pin edge only 3-4 system cycles later
  task automatic frame(input logic [16:0] tx, input int nbits,
                       output logic [16:0] rx);
    rx = '0;
    o_sel_n = 1'b0;
    #(2 * HALF_NS);
    rx[0] = i_serial_out_oe ? i_serial_out : 1'bx;
    for (int k = 0; k < nbits; k++) begin
      // data set at the rise, steady across the fall
      o_sclk = 1'b1;
      o_serial_in = tx[k];
      #(HALF_NS);
      o_sclk = 1'b0;
      #(HALF_NS);
      rx[k] = i_serial_out_oe ? i_serial_out : 1'bx;
    end
    o_serial_in = 1'b0;
    o_sel_n = 1'b1;
    #(2 * HALF_NS);
  endtask

  task automatic idle_clocks(input int n);
    repeat (n) begin
      o_sclk = 1'b1;
      o_serial_in = 1'b1;
      #(HALF_NS);
      o_sclk = 1'b0;
      o_serial_in = 1'b0;
      #(HALF_NS);
    end
  endtask
endmodule

/* File: testbench/hbs_serial_ctl_asserts.sv */
// hbs_serial_ctl_asserts: port-level checks of the serial control block.
// assumes it is bound to hbs_serial_ctl and sees its ports only.
`timescale 1ns/10ps
module hbs_serial_ctl_asserts import hbs_pkg::*; (
  input wire logic                i_clk_sys,
  input wire logic                i_rstn,
  input wire logic                i_sel_n,
  input wire logic                i_sclk,
  input wire logic                i_thermal_warn,
  input wire logic                i_thermal_shutdown,
  input wire logic                o_serial_out,
  input wire logic                o_serial_out_oe,
  input wire logic [SW_COUNT-1:0] o_switch_on,
  input wire logic                o_open_load_check_n,
  input wire logic                o_standby,
  input wire logic [15:0]         o_control_word,
  input wire logic [15:0]         o_status_word
);
  logic [7:0]          edge_age_q;
  logic [7:0]          sel_rise_age_q;
  logic [SW_COUNT-1:0] sw_extra;

  assign sw_extra = o_switch_on & ~o_control_word[12:1];

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  // ==========================================================
  // ages since pin events; pins reach the core some cycles late
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || $rose(i_sclk) || $fell(i_sel_n)) begin
      edge_age_q <= 8'h00;
    end else if (edge_age_q != 8'hFF) begin
      edge_age_q <= edge_age_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || $rose(i_sel_n)) begin
      sel_rise_age_q <= 8'h00;
    end else if (sel_rise_age_q != 8'hFF) begin
      sel_rise_age_q <= sel_rise_age_q + 8'h01;
    end
  end

  // ==========================================================
  // assertions
  AST_OE_START: assert property (
    $fell(i_sel_n) |-> ##[1:8] o_serial_out_oe)
    else $error("output not enabled after select fall");
  AST_OE_IDLE: assert property (
    i_sel_n [*8] |-> !o_serial_out_oe)
    else $error("output driven while deselected");
  AST_OUT_STEP: assert property (
    o_serial_out_oe && $changed(o_serial_out) |-> edge_age_q <= 8'h08)
    else $error("serial output moved away from a clock rise");
  AST_CTL_APPLY: assert property (
    $changed(o_control_word) |-> sel_rise_age_q <= 8'h0A)
    else $error("control word changed away from select rise");
  AST_SW_FOLLOW: assert property (
    sw_extra != '0 |-> ##1 sw_extra == '0)
    else $error("switch on without its control bit");
  AST_OLC_FOLLOW: assert property (
    !$changed(o_control_word[13]) |->
      o_open_load_check_n == o_control_word[13])
    else $error("open-load check output differs from bit 13");
  AST_STBY_SW: assert property (
    !o_control_word[15] |-> ##[0:2] o_standby)
    else $error("software standby not shown");
  AST_STBY_OFF: assert property (
    o_standby [*3] |-> o_switch_on == '0)
    else $error("switch on during standby");
  AST_STAT_STBY: assert property (
    o_standby [*5] |-> o_status_word[14])
    else $error("standby not in status bit 14");
  AST_TP_FLAG: assert property (
    i_thermal_warn [*8] |-> ##1 o_status_word[0])
    else $error("thermal warning not in status bit 0");
  AST_OVERTEMP: assert property (
    i_thermal_shutdown [*8] |-> ##1 o_status_word == 16'hFFFF)
    else $error("status not all ones in overtemperature");
endmodule

bind hbs_serial_ctl hbs_serial_ctl_asserts i_hbs_serial_ctl_asserts (
  .i_clk_sys, .i_rstn, .i_sel_n, .i_sclk, .i_thermal_warn,
  .i_thermal_shutdown, .o_serial_out, .o_serial_out_oe, .o_switch_on,
  .o_open_load_check_n, .o_standby, .o_control_word, .o_status_word
);

/* File: testbench/testbench.sv */
// testbench: self-checking bench for the half-bridge serial control block.
// assumes the host model drives the link pins; faults are driven here.
`timescale 1ns/10ps
module testbench;
  import hbs_pkg::*;
  typedef struct {
    logic [15:0]         tx;
    logic [SW_COUNT-1:0] sw;
    logic                stby;
  } hbs_row_t;
  localparam int          SL = 40;
  localparam int          SS = 10;
  localparam logic [11:0] OL = 12'hA5C;
  logic                clk_sys, rstn, sel_n, sclk, sdi, inh_n, warn, hot;
  logic                under, sdo, sdo_oe, olc_n, stby;
  logic [SW_COUNT-1:0] short_det, sw_on, ol;
  logic [15:0]         ctl, st, prev;
  logic [16:0]         rx;
  int                  miscompares, checks;
  hbs_row_t            rows [5];

  hbs_serial_ctl #(.SHORT_LONG_CYC(SL), .SHORT_SHORT_CYC(SS),
    .UV_DELAY_CYC(8)) i_hbs_serial_ctl (
    .i_clk_sys(clk_sys), .i_rstn(rstn), .i_sel_n(sel_n), .i_sclk(sclk),
    .i_serial_in(sdi), .i_standby_request_n(inh_n), .i_thermal_warn(warn),
    .i_thermal_shutdown(hot), .i_supply_under(under),
    .i_short_det(short_det), .i_open_load(ol), .o_serial_out(sdo),
    .o_serial_out_oe(sdo_oe), .o_switch_on(sw_on),
    .o_open_load_check_n(olc_n), .o_standby(stby),
    .o_control_word(ctl), .o_status_word(st));

  hbs_host_model i_hbs_host_model (
    .o_sel_n(sel_n), .o_sclk(sclk), .o_serial_in(sdi),
    .i_serial_out(sdo), .i_serial_out_oe(sdo_oe));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic send(input logic [15:0] w);
    i_hbs_host_model.frame({1'b0, w}, 16, rx);
    cyc(2);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (checks > 0 && miscompares == 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_st(input logic [15:0] c);
    logic [11:0] s;
    s = c[12:1] | (~{12{c[13]}} & ol);
    exp_st = {1'b0, ~c[15] | ~inh_n, 1'b0, s, warn};
  endfunction

  task automatic do_reset;
    rstn = 1'b0;
    cyc(10);
    chk(ctl, 16'hE000);
    chk({sw_on, sdo_oe, olc_n, stby, 1'b0}, 16'h0006);
    rstn = 1'b1;
    cyc(8);
    chk(16'(stby), 16'h0000);
    $display("test reset done");
  endtask

  // long delay must not fire early, short one must; clear then re-enables
  task automatic short_run(input logic [15:0] w, input logic early);
    send(w);
    short_det = 12'h001;
    cyc(SS + 8);
    chk(16'(st[13]), 16'(early));
    cyc(SL);
    chk({st[13], 3'b000, sw_on}, 16'h8000);
    short_det = 12'h000;
    send(w | 16'h0001);
    chk(st, 16'h0002);
    $display("test short done");
  endtask

  // ==========================================================
  // budget: about 15 frames of 3 us plus fault waits
  initial begin
    #500000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    rows = '{'{16'hFFFE, 12'hFFF, 1'b0}, '{16'h8AAA, 12'h555, 1'b0},
             '{16'hC554, 12'h2AA, 1'b0}, '{16'h6000, 12'h000, 1'b1},
             '{16'hE001, 12'h000, 1'b0}};
    rstn = 1'b0;
    inh_n = 1'b1;
    warn = 1'b0;
    hot = 1'b0;
    under = 1'b0;
    short_det = '0;
    ol = OL;
    miscompares = 0;
    checks = 0;
    do_reset;
    prev = 16'hE000;
    foreach (rows[i]) begin
      send(rows[i].tx);
      chk(rx[15:0], exp_st(prev));
      chk(ctl, rows[i].tx);
      chk({4'h0, sw_on}, {4'h0, rows[i].sw});
      chk(16'(olc_n), 16'(rows[i].tx[13]));
      chk(16'(stby), 16'(rows[i].stby));
      prev = rows[i].tx;
    end
    $display("test table done");
    i_hbs_host_model.frame(17'h0_8002, 15, rx);
    i_hbs_host_model.frame(17'h1_8002, 17, rx);
    i_hbs_host_model.idle_clocks(4);
    cyc(2);
    chk(ctl, 16'hE001);
    warn = 1'b1;
    cyc(8);
    i_hbs_host_model.frame(17'h0_0000, 0, rx);
    cyc(2);
    chk(16'(rx[0]), 16'h0001);
    chk(ctl, 16'hE001);
    warn = 1'b0;
    $display("test refused frames done");
    short_run(16'hE002, 1'b0);
    short_run(16'hA002, 1'b1);
    send(16'hE002);
    hot = 1'b1;
    cyc(10);
    chk({4'h0, sw_on}, 16'h0000);
    hot = 1'b0;
    cyc(10);
    chk(st, 16'hFFFF);
    send(16'hE003);
    chk(st, 16'h0002);
    $display("test overtemp done");
    under = 1'b1;
    cyc(20);
    chk({st[15], 3'b000, sw_on}, 16'h8000);
    under = 1'b0;
    cyc(8);
    chk({st[15], 3'b000, sw_on}, 16'h8001);
    send(16'hE003);
    chk(st, 16'h0002);
    $display("test undervoltage done");
    inh_n = 1'b0;
    cyc(8);
    chk({stby, st[14], 2'b00, sw_on}, 16'hC000);
    inh_n = 1'b1;
    cyc(8);
    chk({stby, st[14], 2'b00, sw_on}, 16'h0001);
    $display("test inhibit done");
    do_reset;
    report_and_stop;
  end
endmodule
